// >>> core/uubc_pkg.sv
// Constants, encodings and baud table for the USB to UART bridge core.
// Behaviour
// - Bus suspend detect enters suspend state
// - Suspend entry asserts both suspend indicators
// - Indicators asserted from reset until configured
// - Resume, bus reset or configuration exit suspend
// - Suspend exit deasserts both indicators
// - Host sets 5-8 data, stop, parity
// - Host selects listed rates 300 to 921600
// - Top rate only with seven/eight bits
// - RTS/CTS, DTR/DSR or XON/XOFF flow control
// - TX, RX and six modem lines provided
// - USB logic carries data and commands
// - USB side is full-speed USB 2.0
// - Blank store yields built-in default descriptors
// - Default power attributes 80h, max 32h
// - Serial max 63, product max 126 chars
// - Store is written over USB commands
// - Locked descriptors refuse further modification; the code clears the lock at reset, after which writes are accepted
// - Positive indicator high, complement low, suspended
// - Modem control lines are active low
package uubc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int NUM_RATES = 29;
  localparam int RATES [NUM_RATES] = '{300, 600, 1200, 1800, 2400, 4000, 4800, 7200, 9600, 14400, 16000,
    19200, 28800, 38400, 51200, 56000, 57600, 64000, 76800, 115200, 128000, 153600, 230400, 250000,
    256000, 460800, 500000, 576000, 921600};
  localparam logic [4:0] TOP_RATE_IDX = 5'h1C;
  localparam logic [4:0] RST_RATE_IDX = 5'h08;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_BAUD = 4'h1;
  localparam logic [3:0] REG_MODEM = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_NVADDR = 4'h4;
  localparam logic [3:0] REG_NVDATA = 4'h5;
  localparam logic [3:0] REG_NVLOCK = 4'h6;
  localparam logic [3:0] REG_POWER = 4'h7;
  // ----------------------------------------------------------------
  // Field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] STOP_1 = 2'h0;
  localparam logic [1:0] STOP_1H = 2'h1;
  localparam logic [1:0] STOP_2 = 2'h2;
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_EVEN = 3'h1;
  localparam logic [2:0] PAR_ODD = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;
  localparam logic [1:0] FLOW_NONE = 2'h0;
  localparam logic [1:0] FLOW_RTS = 2'h1;
  localparam logic [1:0] FLOW_DTR = 2'h2;
  localparam logic [1:0] FLOW_XON = 2'h3;
  localparam logic [1:0] BITS_5 = 2'h0;
  localparam logic [9:0] CFG_RST = 10'h003;
  localparam int ST_ERR_BIT = 3;
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
  // ----------------------------------------------------------------
  // Descriptor store layout and defaults
  // ----------------------------------------------------------------
  localparam logic [7:0] NV_ATTR = 8'h00;
  localparam logic [7:0] NV_MAXPWR = 8'h01;
  localparam logic [7:0] NV_SER_LEN = 8'h02;
  localparam logic [7:0] NV_PROD_LEN = 8'h03;
  localparam logic [7:0] SER_MAX = 8'h3F;
  localparam logic [7:0] PROD_MAX = 8'h7E;
  localparam logic [7:0] DEF_ATTR = 8'h80;
  localparam logic [7:0] DEF_MAXPWR = 8'h32;
  localparam logic [7:0] LOCK_KEY = 8'hA5;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uubc_tx_e;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uubc_rx_e;
endpackage

// >>> core/uubc_store.sv
// Small byte memory that models the descriptor store, with registered read data.
`timescale 1ns/1ps
module uubc_store #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_ff
);
  logic [DW-1:0] mem [2**AW];
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    rdata_ff <= mem[addr];
  end
endmodule // uubc_store

// >>> core/usb_uart_bridge_core.sv
// Bridge core: suspend indicators, command registers, UART transmitter and receiver, descriptor store.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module usb_uart_bridge_core import uubc_pkg::*; #(
  parameter int NV_AW = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic usb_suspend_det,
  input wire logic usb_resume_det,
  input wire logic usb_bus_reset,
  input wire logic usb_configured,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_ff,
  input wire logic [7:0] usb_tx_data,
  input wire logic usb_tx_valid,
  output logic usb_tx_ready_ff,
  output logic [7:0] usb_rx_data_ff,
  output logic usb_rx_valid_ff,
  output logic txd_ff,
  input wire logic rxd,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic ri_n,
  output logic rts_n_ff,
  output logic dtr_n_ff,
  output logic suspend_ff,
  output logic suspend_n_ff
);
  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [9:0] cfg_ff;
  logic [4:0] rate_ff;
  logic [15:0] div_ff;
  logic [1:0] modem_ff;
  logic err_ff, lock_ff, blank_ff;
  logic [NV_AW-1:0] nv_addr_ff;
  logic [7:0] attr_ff, maxpwr_ff, nv_rdata;
  logic xoff_ff;
  uubc_tx_e tx_st_ff;
  logic [15:0] div_tab [NUM_RATES];
  genvar g;
  generate
    for (g = 0; g < NUM_RATES; g++) begin : g_div
      assign div_tab[g] = 16'(CLK_HZ / (2 * RATES[g]));
    end
  endgenerate

  function automatic logic cfg_ok(input logic [9:0] c, input logic [4:0] r);
    // Five-bit only half stop, seven/eight bit only top rate, legal codes.
    cfg_ok = (c[3:2] != 2'h3) && (c[6:4] <= PAR_SPACE) && (r < 5'(NUM_RATES))
      && !(c[3:2] == STOP_1H && c[1:0] != BITS_5)
      && !(r == TOP_RATE_IDX && c[1:0] < 2'h2);
  endfunction

  wire wr_cfg = reg_wr && reg_addr == REG_CFG;
  wire wr_baud = reg_wr && reg_addr == REG_BAUD;
  wire [9:0] cand_cfg = wr_cfg ? reg_wdata[9:0] : cfg_ff;
  wire [4:0] cand_rate = wr_baud ? reg_wdata[4:0] : rate_ff;
  wire cfg_good = cfg_ok(cand_cfg, cand_rate);
  wire cfg_apply = (wr_cfg || wr_baud) && cfg_good;
  wire cfg_reject = (wr_cfg || wr_baud) && !cfg_good;
  wire err_clr = reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_ERR_BIT];
  wire nv_len_bad = (nv_addr_ff == NV_SER_LEN && reg_wdata[7:0] > SER_MAX)
    || (nv_addr_ff == NV_PROD_LEN && reg_wdata[7:0] > PROD_MAX);
  wire nv_wr = reg_wr && reg_addr == REG_NVDATA && !lock_ff && !nv_len_bad;
  wire nv_reject = reg_wr && reg_addr == REG_NVDATA && (lock_ff || nv_len_bad);
  wire [7:0] pwr_attr = blank_ff ? DEF_ATTR : attr_ff;
  wire [7:0] pwr_max = blank_ff ? DEF_MAXPWR : maxpwr_ff;
  wire tx_busy = tx_st_ff != TX_IDLE;
  wire [15:0] status_word = {10'h000, blank_ff, lock_ff, err_ff, xoff_ff, tx_busy, suspend_ff};
  wire [15:0] modem_word = {10'h000, !ri_n, !dcd_n, !dsr_n, !cts_n, modem_ff};
  wire [15:0] nxt_rdata = (!reg_rd) ? 16'h0000 :
    (reg_addr == REG_CFG) ? {6'h00, cfg_ff} :
    (reg_addr == REG_BAUD) ? {11'h000, rate_ff} :
    (reg_addr == REG_MODEM) ? modem_word :
    (reg_addr == REG_STATUS) ? status_word :
    (reg_addr == REG_NVADDR) ? 16'(nv_addr_ff) :
    (reg_addr == REG_NVDATA) ? {8'h00, nv_rdata} :
    (reg_addr == REG_NVLOCK) ? {15'h0000, lock_ff} :
    (reg_addr == REG_POWER) ? {pwr_max, pwr_attr} : 16'h0000;

  uubc_store #(.AW(NV_AW), .DW(8)) u_store (
    .sys_clk(sys_clk),
    .wr_en(nv_wr),
    .addr(nv_addr_ff),
    .wdata(reg_wdata[7:0]),
    .rdata_ff(nv_rdata)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_ff <= CFG_RST;
      rate_ff <= RST_RATE_IDX;
      div_ff <= 16'(CLK_HZ / (2 * RATES[RST_RATE_IDX]));
      err_ff <= 1'b0;
    end else begin
      if (cfg_apply) begin
        cfg_ff <= cand_cfg;
        rate_ff <= cand_rate;
        div_ff <= div_tab[cand_rate];
      end
      err_ff <= cfg_reject || nv_reject || (err_ff && !err_clr);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      modem_ff <= 2'h0;
      nv_addr_ff <= '0;
      lock_ff <= 1'b0;
      blank_ff <= 1'b1;
      attr_ff <= DEF_ATTR;
      maxpwr_ff <= DEF_MAXPWR;
      reg_rdata_ff <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == REG_MODEM) modem_ff <= reg_wdata[1:0];
      if (reg_wr && reg_addr == REG_NVADDR) nv_addr_ff <= reg_wdata[NV_AW-1:0];
      if (reg_wr && reg_addr == REG_NVLOCK && reg_wdata[7:0] == LOCK_KEY) lock_ff <= 1'b1;
      if (nv_wr) blank_ff <= 1'b0;
      if (nv_wr && nv_addr_ff == NV_ATTR) attr_ff <= reg_wdata[7:0];
      if (nv_wr && nv_addr_ff == NV_MAXPWR) maxpwr_ff <= reg_wdata[7:0];
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Suspend indicators
  // ----------------------------------------------------------------
  // Leaving events win over a simultaneous suspend detect, so a resume is never lost.
  wire susp_exit = usb_resume_det || usb_bus_reset || usb_configured;
  wire nxt_susp = susp_exit ? 1'b0 : (usb_suspend_det ? 1'b1 : suspend_ff);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      suspend_ff <= 1'b1;
      suspend_n_ff <= 1'b0;
    end else begin
      suspend_ff <= nxt_susp;
      suspend_n_ff <= !nxt_susp;
    end
  end

  // ----------------------------------------------------------------
  // Serial format
  // ----------------------------------------------------------------
  wire [3:0] nbits = 4'(cfg_ff[1:0]) + 4'h5;
  wire [2:0] parity = cfg_ff[6:4];
  wire [1:0] flow = cfg_ff[9:8];
  wire [2:0] stop_halves = (cfg_ff[3:2] == STOP_1) ? 3'h2 : (cfg_ff[3:2] == STOP_1H) ? 3'h3 : 3'h4;
  function automatic logic par_bit(input logic [7:0] d, input logic [2:0] p, input logic [3:0] n);
    logic [7:0] m;
    m = d & 8'(8'hFF >> (4'h8 - n));
    par_bit = (p == PAR_EVEN) ? ^m : (p == PAR_ODD) ? ~^m : (p == PAR_MARK);
  endfunction
  wire hold = (flow == FLOW_RTS && cts_n) || (flow == FLOW_DTR && dsr_n)
    || (flow == FLOW_XON && xoff_ff);

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [15:0] tx_cnt_ff;
  logic [2:0] tx_half_ff;
  logic [2:0] tx_bit_ff;
  logic [7:0] tx_sh_ff;
  logic tx_par_ff;
  wire tx_take = usb_tx_valid && usb_tx_ready_ff;
  wire tx_tick = tx_busy && tx_cnt_ff == 16'h0000;
  wire [2:0] tx_need = (tx_st_ff == TX_STOP) ? stop_halves : 3'h2;
  wire tx_bit_end = tx_tick && (tx_half_ff + 3'h1) == tx_need;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_st_ff <= TX_IDLE;
      tx_cnt_ff <= 16'h0000;
      tx_half_ff <= 3'h0;
      tx_bit_ff <= 3'h0;
      tx_sh_ff <= 8'h00;
      tx_par_ff <= 1'b0;
      txd_ff <= 1'b1;
      usb_tx_ready_ff <= 1'b0;
    end else begin
      usb_tx_ready_ff <= (tx_st_ff == TX_IDLE) && !tx_take && !hold;
      tx_cnt_ff <= (tx_take || tx_tick) ? div_ff - 16'h0001 : tx_cnt_ff - 16'(tx_busy);
      if (tx_tick) tx_half_ff <= tx_bit_end ? 3'h0 : tx_half_ff + 3'h1;
      case (tx_st_ff)
        TX_IDLE: begin
          if (tx_take) begin
            tx_st_ff <= TX_START;
            tx_sh_ff <= usb_tx_data;
            tx_par_ff <= par_bit(usb_tx_data, parity, nbits);
            tx_half_ff <= 3'h0;
            txd_ff <= 1'b0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_st_ff <= TX_DATA;
            tx_bit_ff <= 3'h0;
            txd_ff <= tx_sh_ff[0];
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_sh_ff <= tx_sh_ff >> 1;
            tx_bit_ff <= tx_bit_ff + 3'h1;
            if (4'(tx_bit_ff) + 4'h1 == nbits) begin
              tx_st_ff <= (parity == PAR_NONE) ? TX_STOP : TX_PAR;
              txd_ff <= (parity == PAR_NONE) ? 1'b1 : tx_par_ff;
            end else begin
              txd_ff <= tx_sh_ff[1];
            end
          end
        end
        TX_PAR: begin
          if (tx_bit_end) begin
            tx_st_ff <= TX_STOP;
            txd_ff <= 1'b1;
          end
        end
        TX_STOP: begin
          if (tx_bit_end) tx_st_ff <= TX_IDLE;
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  // Sampling at mid bit from the start edge; no oversampling filter, so noisy lines need clean edges.
  uubc_rx_e rx_st_ff;
  logic [15:0] rx_cnt_ff;
  logic rx_half_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  wire rx_tick = rx_st_ff != RX_IDLE && rx_cnt_ff == 16'h0000;
  wire rx_samp = rx_tick && (rx_st_ff == RX_START || rx_half_ff);
  wire [7:0] rx_byte = rx_sh_ff >> (4'h8 - nbits);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_st_ff <= RX_IDLE;
      rx_cnt_ff <= 16'h0000;
      rx_half_ff <= 1'b0;
      rx_bit_ff <= 3'h0;
      rx_sh_ff <= 8'h00;
      usb_rx_data_ff <= 8'h00;
      usb_rx_valid_ff <= 1'b0;
      xoff_ff <= 1'b0;
    end else begin
      usb_rx_valid_ff <= 1'b0;
      rx_cnt_ff <= (rx_tick || rx_st_ff == RX_IDLE) ? div_ff - 16'h0001 : rx_cnt_ff - 16'h0001;
      if (rx_tick) rx_half_ff <= rx_samp ? 1'b0 : 1'b1;
      if (flow != FLOW_XON) xoff_ff <= 1'b0;
      case (rx_st_ff)
        RX_IDLE: begin
          rx_half_ff <= 1'b0;
          if (!rxd) rx_st_ff <= RX_START;
        end
        RX_START: begin
          if (rx_samp) begin
            rx_st_ff <= rxd ? RX_IDLE : RX_DATA;
            rx_bit_ff <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_samp) begin
            rx_sh_ff <= {rxd, rx_sh_ff[7:1]};
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (4'(rx_bit_ff) + 4'h1 == nbits) rx_st_ff <= (parity == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
        RX_PAR: begin
          if (rx_samp) rx_st_ff <= RX_STOP;
        end
        RX_STOP: begin
          if (rx_samp) begin
            rx_st_ff <= RX_IDLE;
            if (rxd) begin
              usb_rx_data_ff <= rx_byte;
              usb_rx_valid_ff <= 1'b1;
              if (flow == FLOW_XON && rx_byte == XOFF_CHAR) xoff_ff <= 1'b1;
              if (flow == FLOW_XON && rx_byte == XON_CHAR) xoff_ff <= 1'b0;
            end
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Modem outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rts_n_ff <= 1'b1;
      dtr_n_ff <= 1'b1;
    end else begin
      rts_n_ff <= !modem_ff[1];
      dtr_n_ff <= !modem_ff[0];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_exit_req;
    usb_resume_det || usb_bus_reset || usb_configured;
  endsequence
  sequence s_susp_req;
    usb_suspend_det && !(usb_resume_det || usb_bus_reset || usb_configured);
  endsequence
  a_suspend_entry: assert property (s_susp_req |=> suspend_ff && !suspend_n_ff)
    else $error("suspend not entered");
  a_suspend_exit: assert property (s_exit_req |=> !suspend_ff ##0 suspend_n_ff)
    else $error("suspend not left");
  a_indicator_pair: assert property (suspend_ff != suspend_n_ff)
    else $error("indicators not complementary");
  a_susp_hold: assert property (!usb_suspend_det && !(usb_resume_det || usb_bus_reset || usb_configured)
    |=> $stable(suspend_ff))
    else $error("suspend changed without cause");
  a_half_stop_five: assert property (cfg_ff[3:2] == STOP_1H |-> cfg_ff[1:0] == BITS_5)
    else $error("half stop with wide char");
  a_top_rate_bits: assert property (rate_ff == TOP_RATE_IDX |-> cfg_ff[1:0] >= 2'h2)
    else $error("top rate with short char");
  a_lock_freeze: assert property (lock_ff |=> $stable(attr_ff) && $stable(maxpwr_ff) && lock_ff)
    else $error("locked store modified");
  a_blank_default: assert property (reg_rd && reg_addr == REG_POWER && blank_ff
    |=> reg_rdata_ff == {DEF_MAXPWR, DEF_ATTR})
    else $error("default power descriptor wrong");
  a_start_bit: assert property (tx_take |=> !txd_ff && tx_st_ff == TX_START)
    else $error("no start bit");
  a_cts_hold: assert property (flow == FLOW_RTS && cts_n && tx_st_ff == TX_IDLE |=> !usb_tx_ready_ff)
    else $error("ready under cts hold");
  a_ser_len: assert property (reg_wr && reg_addr == REG_NVDATA && nv_addr_ff == NV_SER_LEN
    && reg_wdata[7:0] > SER_MAX |=> err_ff)
    else $error("serial length too long");
endmodule // usb_uart_bridge_core

// >>> testbench/uubc_peer.sv
// Serial peer model: drives the receive line and the modem inputs of the bridge.
`timescale 1ns/1ps
module uubc_peer (
  input wire logic sys_clk,
  output logic rxd,
  output logic cts_n,
  output logic dsr_n,
  output logic dcd_n,
  output logic ri_n
);
  // Modem inputs start deasserted, which is the high level.
  initial begin
    rxd = 1'b1;
    cts_n = 1'b1;
    dsr_n = 1'b1;
    dcd_n = 1'b1;
    ri_n = 1'b1;
  end
  // One 8N1 character; the line is left at the stop level, which is also the idle level.
  task automatic send(input logic [7:0] b, input int bit_cyc);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      rxd <= fr[i];
      repeat (bit_cyc - 1) @(posedge sys_clk);
    end
  endtask
endmodule // uubc_peer

// >>> testbench/usb_uart_bridge_core_bench.sv
// Self-checking bench for the bridge core with a reference model of framing, flow and registers.
`timescale 1ns/1ps
module usb_uart_bridge_core_bench import uubc_pkg::*;;
  logic sys_clk, rst, sdet, rdet, brst, conf, reg_wr, reg_rd, tx_valid, tx_ready, rx_valid, txd, rxd;
  logic cts_n, dsr_n, dcd_n, ri_n, rts_n, dtr_n, susp, susp_n;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, rdata, rd;
  logic [7:0] tx_data, rx_data, lfsr;
  int bad_count, total_checks, half;
  usb_uart_bridge_core u_dut (.sys_clk(sys_clk), .rst(rst), .usb_suspend_det(sdet), .usb_resume_det(rdet),
    .usb_bus_reset(brst), .usb_configured(conf), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(rdata), .usb_tx_data(tx_data), .usb_tx_valid(tx_valid),
    .usb_tx_ready_ff(tx_ready), .usb_rx_data_ff(rx_data), .usb_rx_valid_ff(rx_valid), .txd_ff(txd),
    .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n), .rts_n_ff(rts_n),
    .dtr_n_ff(dtr_n), .suspend_ff(susp), .suspend_n_ff(susp_n));
  uubc_peer u_peer (.sys_clk(sys_clk), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .dcd_n(dcd_n), .ri_n(ri_n));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [15:0] cfgw(input logic [1:0] b, input logic [1:0] s, input logic [2:0] p,
    input logic [1:0] f);
    return {6'h00, f, 1'b0, p, s, b};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rd = rdata;
  endtask
  task automatic ev(input int k, input logic exp);
    @(posedge sys_clk);
    sdet <= (k == 0);
    rdet <= (k == 1);
    brst <= (k == 2);
    conf <= (k == 3);
    @(posedge sys_clk);
    {sdet, rdet, brst, conf} <= 4'h0;
    #1 chk("suspend", 16'(susp), 16'(exp));
    chk("suspend_n", 16'(susp_n), 16'(!exp));
  endtask
  // Builds the expected frame as a bit queue, then samples txd near the middle of every bit.
  task automatic xmit(input logic [7:0] d, input int nb, input logic [2:0] par, input logic [1:0] stp);
    logic fr[$];
    int ones, k;
    ones = 0;
    k = 0;
    fr.push_back(1'b0);
    for (int i = 0; i < nb; i++) begin
      fr.push_back(d[i]);
      ones += d[i];
    end
    case (par)
      PAR_EVEN: fr.push_back(ones % 2 == 1);
      PAR_ODD: fr.push_back(ones % 2 == 0);
      PAR_MARK: fr.push_back(1'b1);
      PAR_SPACE: fr.push_back(1'b0);
      default: ;
    endcase
    fr.push_back(1'b1);
    if (stp == STOP_2) fr.push_back(1'b1);
    @(posedge sys_clk);
    tx_data <= d;
    tx_valid <= 1'b1;
    do @(negedge sys_clk); while (tx_ready !== 1'b1 && ++k < 400);
    @(posedge sys_clk);
    tx_valid <= 1'b0;
    @(negedge sys_clk);
    chk("ready busy", 16'(tx_ready), 16'h0000);
    repeat (half - 1) @(negedge sys_clk);
    foreach (fr[i]) begin
      chk("txd bit", 16'(txd), 16'(fr[i]));
      repeat (2 * half) @(negedge sys_clk);
    end
    k = 0;
    while (tx_ready !== 1'b1 && ++k < 400) @(negedge sys_clk);
  endtask
  task automatic rx_one(input logic [7:0] b);
    int k;
    k = 0;
    fork
      u_peer.send(b, 2 * half);
      begin
        do @(negedge sys_clk); while (rx_valid !== 1'b1 && ++k < 400);
        chk("rx valid", 16'(rx_valid), 16'h0001);
        chk("rx byte", 16'(rx_data), 16'(b));
      end
    join
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk);
    bad_count++;
    $display("BAD watchdog expected done seen hang");
    finish_test;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {sdet, rdet, brst, conf, reg_wr, reg_rd, tx_valid} = 7'h00;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    tx_data = 8'h00;
    lfsr = 8'h30;
    half = CLK_HZ / (2 * RATES[27]);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk("reset suspend", {susp, susp_n}, 16'h0002);
    chk("idle lines", {txd, rts_n, dtr_n}, 16'h0007);
    rdr(REG_CFG); chk("cfg", rd, 16'(CFG_RST));
    rdr(REG_BAUD); chk("baud", rd, 16'(RST_RATE_IDX));
    rdr(REG_POWER); chk("power", rd, {DEF_MAXPWR, DEF_ATTR});
    rdr(REG_STATUS); chk("status", 16'(rd[5:0]), 16'h0021);
    rdr(4'hF); chk("unmapped", rd, 16'h0000);
    $display("test reset done");
    ev(3, 1'b0);
    ev(0, 1'b1);
    ev(1, 1'b0);
    ev(0, 1'b1);
    ev(2, 1'b0);
    $display("test suspend done");
    wr(REG_CFG, cfgw(2'h3, STOP_1H, PAR_NONE, FLOW_NONE));
    rdr(REG_CFG); chk("cfg refused", rd, 16'(CFG_RST));
    rdr(REG_STATUS); chk("err", 16'(rd[ST_ERR_BIT]), 16'h0001);
    wr(REG_STATUS, 16'h0008);
    rdr(REG_STATUS); chk("err clear", 16'(rd[ST_ERR_BIT]), 16'h0000);
    wr(REG_CFG, cfgw(BITS_5, STOP_1H, PAR_MARK, FLOW_NONE));
    rdr(REG_CFG); chk("cfg 5 bit", rd, cfgw(BITS_5, STOP_1H, PAR_MARK, FLOW_NONE));
    wr(REG_BAUD, 16'h001C);
    rdr(REG_BAUD); chk("top rate refused", rd, 16'(RST_RATE_IDX));
    wr(REG_BAUD, 16'h001D);
    rdr(REG_BAUD); chk("bad index", rd, 16'(RST_RATE_IDX));
    wr(REG_CFG, cfgw(2'h2, STOP_2, PAR_SPACE, FLOW_NONE));
    wr(REG_BAUD, 16'(TOP_RATE_IDX));
    rdr(REG_BAUD); chk("top rate", rd, 16'(TOP_RATE_IDX));
    wr(REG_STATUS, 16'h0008);
    $display("test config done");
    for (int p = 0; p < 5; p++) begin
      wr(REG_BAUD, 16'h001B);
      wr(REG_CFG, cfgw(2'(p % 4), (p == 0) ? STOP_1H : ((p % 2 == 1) ? STOP_2 : STOP_1), 3'(p), FLOW_NONE));
      xmit(lfsr, 5 + p % 4, 3'(p), (p % 2 == 1) ? STOP_2 : STOP_1);
      lfsr = nxt(lfsr);
    end
    $display("test transmit done");
    // Hold-off is seen as ready staying low while the byte waits.
    wr(REG_CFG, cfgw(2'h3, STOP_1, PAR_NONE, FLOW_RTS));
    fork
      xmit(lfsr, 8, PAR_NONE, STOP_1);
      begin
        // Ready still shows the old flow mode for one edge after the write lands.
        @(posedge sys_clk);
        repeat (20) begin
          @(negedge sys_clk);
          chk("cts hold", 16'(tx_ready), 16'h0000);
        end
        @(posedge sys_clk);
        u_peer.cts_n <= 1'b0;
      end
    join
    @(posedge sys_clk);
    u_peer.ri_n <= 1'b0;
    wr(REG_MODEM, 16'h0003);
    rdr(REG_MODEM); chk("modem", 16'(rd[5:0]), 16'h0027);
    chk("modem outs", {rts_n, dtr_n}, 16'h0000);
    wr(REG_CFG, cfgw(2'h3, STOP_1, PAR_NONE, FLOW_DTR));
    repeat (3) @(negedge sys_clk);
    chk("dsr hold", 16'(tx_ready), 16'h0000);
    @(posedge sys_clk);
    u_peer.dsr_n <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("dsr go", 16'(tx_ready), 16'h0001);
    wr(REG_CFG, cfgw(2'h3, STOP_1, PAR_NONE, FLOW_NONE));
    lfsr = nxt(lfsr);
    rx_one(lfsr);
    wr(REG_CFG, cfgw(2'h3, STOP_1, PAR_NONE, FLOW_XON));
    u_peer.send(XOFF_CHAR, 2 * half);
    repeat (3 * half) @(posedge sys_clk);
    rdr(REG_STATUS); chk("xoff", {rd[2], 7'h00, tx_ready}, 16'h0100);
    u_peer.send(XON_CHAR, 2 * half);
    repeat (3 * half) @(posedge sys_clk);
    rdr(REG_STATUS); chk("xon", {rd[2], 7'h00, tx_ready}, 16'h0001);
    $display("test flow done");
    wr(REG_NVADDR, 16'(NV_SER_LEN));
    wr(REG_NVDATA, 16'h0040);
    rdr(REG_STATUS); chk("serial len err", 16'(rd[ST_ERR_BIT]), 16'h0001);
    wr(REG_NVDATA, 16'(SER_MAX));
    rdr(REG_NVDATA); chk("serial len", rd, 16'(SER_MAX));
    wr(REG_NVADDR, 16'(NV_PROD_LEN));
    wr(REG_NVDATA, 16'(PROD_MAX));
    wr(REG_NVDATA, 16'h007F);
    rdr(REG_NVDATA); chk("product len", rd, 16'(PROD_MAX));
    wr(REG_NVADDR, 16'(NV_ATTR));
    wr(REG_NVDATA, 16'h0090);
    wr(REG_NVADDR, 16'(NV_MAXPWR));
    wr(REG_NVDATA, 16'h0010);
    rdr(REG_POWER); chk("stored power", rd, 16'h1090);
    wr(REG_NVLOCK, 16'(LOCK_KEY));
    rdr(REG_NVLOCK); chk("lock", 16'(rd[0]), 16'h0001);
    wr(REG_STATUS, 16'h0008);
    wr(REG_NVDATA, 16'h0020);
    rdr(REG_POWER); chk("locked power", rd, 16'h1090);
    rdr(REG_STATUS); chk("locked err", 16'(rd[5:3]), 16'h0003);
    $display("test store done");
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk("rereset suspend", {susp, susp_n}, 16'h0002);
    rdr(REG_STATUS); chk("rereset status", 16'(rd[5:0]), 16'h0021);
    $display("test second reset done");
    finish_test;
  end
endmodule // usb_uart_bridge_core_bench
